// ==== inc/sgol_cfg.svh ====
// constants of the safety gate output logic
`ifndef SGOL_CFG_SVH
`define SGOL_CFG_SVH

`define SGOL_CLK_MHZ 250
`define SGOL_DIAG_BIT_NS 10000
`define SGOL_DIAG_BIT_CYC ((`SGOL_DIAG_BIT_NS * `SGOL_CLK_MHZ) / 1000)
`define SGOL_DIAG_DET_US 1000
`define SGOL_DIAG_DET_CYC (`SGOL_DIAG_DET_US * `SGOL_CLK_MHZ)
`define SGOL_LED_HALF_MS 250
`define SGOL_LED_HALF_CYC (`SGOL_LED_HALF_MS * `SGOL_CLK_MHZ * 1000)

`define SGOL_OP_POLL 4'h1
`define SGOL_OP_SERIAL 4'h2
`define SGOL_OP_TEACH 4'h3
`define SGOL_OP_NAME 4'h4
`define SGOL_OP_WRITE 4'h5
`define SGOL_OP_REFRESH 4'h6

`define SGOL_ACK_BYTE 8'h06
`define SGOL_PARAM_RST 8'h00
`define SGOL_CODE_RST 8'h00

`define SGOL_ST_LEARNED 0
`define SGOL_ST_PRESENT 1
`define SGOL_ST_CH2 2
`define SGOL_ST_CH1 3
`define SGOL_ST_DISCREP 4
`define SGOL_ST_PLAUS 5
`define SGOL_ST_LOCK 6
`define SGOL_ST_DIAG 7

`endif

// ==== inc/sgol_pkg.sv ====
// types of the safety gate output logic
`include "sgol_cfg.svh"

package sgol_pkg;

	typedef enum logic [3:0] {
		PL_WAIT_LOW = 4'b0001,
		PL_NORMAL = 4'b0010,
		PL_DISCREP = 4'b0100,
		PL_LOCKED = 4'b1000
	} sgol_plaus_t;

	typedef enum logic [2:0] {
		DG_DETECT = 3'b001,
		DG_IDLE = 3'b010,
		DG_WDATA = 3'b100
	} sgol_diag_t;

	typedef enum logic [3:0] {
		OP_POLL = `SGOL_OP_POLL,
		OP_SERIAL = `SGOL_OP_SERIAL,
		OP_TEACH = `SGOL_OP_TEACH,
		OP_NAME = `SGOL_OP_NAME,
		OP_WRITE = `SGOL_OP_WRITE,
		OP_REFRESH = `SGOL_OP_REFRESH
	} sgol_op_t;

endpackage

// ==== src/sgol_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module sgol_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			meta_q <= '0;
			q_out <= '0;
		end else if (ce_in) begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ==== src/sgol_top.sv ====
// safety output, plausibility and diagnostic link logic of the gate switch
`timescale 1ns/10ps
`default_nettype none
`include "sgol_cfg.svh"

module sgol_top
	import sgol_pkg::*;
#(
	parameter int DEV_ADDR = 0,
	parameter int BIT_CYCLES = `SGOL_DIAG_BIT_CYC,
	parameter int DET_CYCLES = `SGOL_DIAG_DET_CYC,
	parameter int FLASH_CYCLES = `SGOL_LED_HALF_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic act_detect_in,
	input wire logic [7:0] act_code_in,
	input wire logic safety_in_ch1_in,
	input wire logic safety_in_ch2_in,
	input wire logic diag_in_in,
	input wire logic [7:0] serial_num_in,
	input wire logic [3:0] teach_left_in,
	output logic safety_out_ch1_out,
	output logic safety_out_ch2_out,
	output logic signal_diag_out_out,
	output logic input_led_flash_out,
	output logic plaus_err_out,
	output logic lock_out,
	output logic diag_mode_out,
	output logic act_present_out,
	output logic name_refresh_out,
	output logic [7:0] param_out
);

	logic [2:0] sync_w;
	logic s1;
	logic s2;
	logic dg;
	logic s1_prev_q;
	logic s2_prev_q;
	logic [1:0] warm_q;
	logic learned_q;
	logic [7:0] code_q;
	logic present_w;
	sgol_plaus_t pl_q;
	logic [31:0] flash_cnt_q;
	logic flash_ph_q;
	sgol_diag_t dg_q;
	logic [31:0] det_cnt_q;
	logic rx_busy_q;
	logic [15:0] rx_cnt_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_valid_q;
	logic tx_req_q;
	logic [7:0] tx_byte_q;
	logic tx_busy_q;
	logic [15:0] tx_cnt_q;
	logic [3:0] tx_bit_q;
	logic [9:0] tx_sh_q;
	logic tx_take_w;
	logic addr_hit_w;
	logic [7:0] status_w;
	logic gate_ok_w;

	sgol_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.d_in({diag_in_in, safety_in_ch2_in, safety_in_ch1_in}),
		.q_out(sync_w)
	);

	assign s1 = sync_w[0];
	assign s2 = sync_w[1];
	assign dg = sync_w[2];

	// learned code is lost at reset; non-volatile keeping lies outside
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			learned_q <= 1'b0;
			code_q <= `SGOL_CODE_RST;
		end else if (ce_in && act_detect_in && !learned_q) begin
			learned_q <= 1'b1;
			code_q <= act_code_in;
		end
	end

	assign present_w = act_detect_in && learned_q && (act_code_in == code_q);

	// the synchroniser shows reset lows for two edges; they must not pass as both-low
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s1_prev_q <= 1'b0;
			s2_prev_q <= 1'b0;
			warm_q <= 2'h0;
		end else if (ce_in) begin
			s1_prev_q <= s1;
			s2_prev_q <= s2;
			if (!warm_q[1]) begin
				warm_q <= warm_q + 2'h1;
			end
		end
	end

	// plausibility of the two chained inputs
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pl_q <= PL_WAIT_LOW;
			plaus_err_out <= 1'b0;
			lock_out <= 1'b0;
		end else if (ce_in) begin
			unique case (pl_q)
				PL_WAIT_LOW: begin
					if (warm_q[1] && !s1 && !s2) begin
						pl_q <= PL_NORMAL;
					end
				end
				PL_NORMAL: begin
					if (s1_prev_q && s2_prev_q && (s1 != s2)) begin
						pl_q <= PL_DISCREP;
					end
				end
				PL_DISCREP: begin
					if (!s1 && !s2) begin
						pl_q <= PL_NORMAL;
					end else if (s1 && s2) begin
						pl_q <= PL_LOCKED;
						plaus_err_out <= 1'b1;
						lock_out <= 1'b1;
					end
				end
				PL_LOCKED: begin
					if (!s1 && !s2) begin
						pl_q <= PL_NORMAL;
						plaus_err_out <= 1'b0;
						lock_out <= 1'b0;
					end
				end
			endcase
		end
	end

	// the edge that latches the lock already drops both outputs
	assign gate_ok_w = (pl_q == PL_NORMAL) || (pl_q == PL_DISCREP && !(s1 && s2));

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			safety_out_ch1_out <= 1'b0;
			safety_out_ch2_out <= 1'b0;
			act_present_out <= 1'b0;
		end else if (ce_in) begin
			safety_out_ch1_out <= present_w && gate_ok_w && s1;
			safety_out_ch2_out <= present_w && gate_ok_w && s2;
			act_present_out <= present_w;
		end
	end

	// indicator blinks in the discrepancy state or while locked
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			flash_cnt_q <= 32'h0;
			flash_ph_q <= 1'b0;
			input_led_flash_out <= 1'b0;
		end else if (ce_in) begin
			if (flash_cnt_q == 32'(FLASH_CYCLES - 1)) begin
				flash_cnt_q <= 32'h0;
				flash_ph_q <= !flash_ph_q;
			end else begin
				flash_cnt_q <= flash_cnt_q + 32'h1;
			end
			input_led_flash_out <= 1'b0;
			if (pl_q == PL_DISCREP || pl_q == PL_LOCKED) begin
				input_led_flash_out <= !flash_ph_q;
			end
		end
	end

	// serial receiver, only listening once a module was found
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rx_busy_q <= 1'b0;
			rx_cnt_q <= 16'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_valid_q <= 1'b0;
		end else if (ce_in) begin
			rx_valid_q <= 1'b0;
			if (!rx_busy_q) begin
				if (diag_mode_out && !dg) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q <= 16'(BIT_CYCLES / 2 - 1);
					rx_bit_q <= 4'h0;
				end
			end else if (rx_cnt_q != 16'h0) begin
				rx_cnt_q <= rx_cnt_q - 16'h1;
			end else begin
				rx_cnt_q <= 16'(BIT_CYCLES - 1);
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0 && dg) begin
					rx_busy_q <= 1'b0;
				end else if (rx_bit_q == 4'h9) begin
					rx_busy_q <= 1'b0;
					rx_valid_q <= dg;
				end else if (rx_bit_q != 4'h0) begin
					rx_sh_q <= {dg, rx_sh_q[7:1]};
				end
			end
		end
	end

	always_comb begin
		status_w = 8'h00;
		status_w[`SGOL_ST_LEARNED] = learned_q;
		status_w[`SGOL_ST_PRESENT] = present_w;
		status_w[`SGOL_ST_CH2] = s2;
		status_w[`SGOL_ST_CH1] = s1;
		status_w[`SGOL_ST_DISCREP] = (pl_q == PL_DISCREP);
		status_w[`SGOL_ST_PLAUS] = plaus_err_out;
		status_w[`SGOL_ST_LOCK] = lock_out;
		status_w[`SGOL_ST_DIAG] = diag_mode_out;
	end

	assign addr_hit_w = rx_valid_q && (rx_sh_q[7:4] == 4'(DEV_ADDR));
	assign tx_take_w = tx_req_q && !tx_busy_q;

	// module detection after each reset, then command handling
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			dg_q <= DG_DETECT;
			diag_mode_out <= 1'b0;
			det_cnt_q <= 32'h0;
			tx_req_q <= 1'b0;
			tx_byte_q <= 8'h00;
			param_out <= `SGOL_PARAM_RST;
			name_refresh_out <= 1'b0;
		end else if (ce_in) begin
			name_refresh_out <= 1'b0;
			if (tx_take_w) begin
				tx_req_q <= 1'b0;
			end
			unique case (dg_q)
				DG_DETECT: begin
					if (!dg) begin
						det_cnt_q <= 32'h0;
					end else if (det_cnt_q == 32'(DET_CYCLES - 1)) begin
						dg_q <= DG_IDLE;
						diag_mode_out <= 1'b1;
					end else begin
						det_cnt_q <= det_cnt_q + 32'h1;
					end
				end
				DG_IDLE: begin
					if (addr_hit_w) begin
						tx_req_q <= 1'b1;
						unique case (sgol_op_t'(rx_sh_q[3:0]))
							OP_POLL: tx_byte_q <= status_w;
							OP_SERIAL: tx_byte_q <= serial_num_in;
							OP_TEACH: tx_byte_q <= {4'h0, teach_left_in};
							OP_NAME: tx_byte_q <= code_q;
							OP_WRITE: begin
								tx_req_q <= tx_take_w ? 1'b0 : tx_req_q;
								dg_q <= DG_WDATA;
							end
							OP_REFRESH: begin
								name_refresh_out <= 1'b1;
								tx_byte_q <= `SGOL_ACK_BYTE;
							end
							default: tx_req_q <= tx_take_w ? 1'b0 : tx_req_q;
						endcase
					end
				end
				DG_WDATA: begin
					if (rx_valid_q) begin
						param_out <= rx_sh_q;
						tx_byte_q <= `SGOL_ACK_BYTE;
						tx_req_q <= 1'b1;
						dg_q <= DG_IDLE;
					end
				end
			endcase
		end
	end

	// serial transmitter, start bit, 8 data bits lsb first, stop bit
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			tx_busy_q <= 1'b0;
			tx_cnt_q <= 16'h0;
			tx_bit_q <= 4'h0;
			tx_sh_q <= 10'h3ff;
		end else if (ce_in) begin
			if (tx_take_w) begin
				tx_busy_q <= 1'b1;
				tx_sh_q <= {1'b1, tx_byte_q, 1'b0};
				tx_cnt_q <= 16'(BIT_CYCLES - 1);
				tx_bit_q <= 4'h0;
			end else if (tx_busy_q) begin
				if (tx_cnt_q != 16'h0) begin
					tx_cnt_q <= tx_cnt_q - 16'h1;
				end else begin
					tx_cnt_q <= 16'(BIT_CYCLES - 1);
					tx_sh_q <= {1'b1, tx_sh_q[9:1]};
					tx_bit_q <= tx_bit_q + 4'h1;
					if (tx_bit_q == 4'h9) begin
						tx_busy_q <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			signal_diag_out_out <= 1'b0;
		end else if (ce_in) begin
			if (diag_mode_out) begin
				signal_diag_out_out <= tx_busy_q ? tx_sh_q[0] : 1'b1;
			end else begin
				signal_diag_out_out <= present_w;
			end
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	sequence s_one_falls;
		ce_in && pl_q == PL_NORMAL && s1_prev_q && s2_prev_q && (s1 != s2);
	endsequence

	sequence s_returns;
		ce_in && pl_q == PL_DISCREP && s1 && s2;
	endsequence

	property p_follow;
		ce_in && present_w && pl_q == PL_NORMAL |=>
			safety_out_ch1_out == $past(s1) && safety_out_ch2_out == $past(s2);
	endproperty
	a_follow: assert property (p_follow)
		else $error("safety output does not follow its input");

	property p_absent;
		ce_in && !present_w |=> !safety_out_ch1_out && !safety_out_ch2_out;
	endproperty
	a_absent: assert property (p_absent)
		else $error("safety output high without actuator");

	property p_safe_lock;
		pl_q == PL_LOCKED || pl_q == PL_WAIT_LOW |=> !safety_out_ch1_out && !safety_out_ch2_out;
	endproperty
	a_safe_lock: assert property (p_safe_lock)
		else $error("safety output high while locked");

	property p_lock_entry;
		s_returns |=> !safety_out_ch1_out && !safety_out_ch2_out;
	endproperty
	a_lock_entry: assert property (p_lock_entry)
		else $error("safety output high on entry to lock");

	property p_signal;
		ce_in && !diag_mode_out |=> signal_diag_out_out == $past(present_w);
	endproperty
	a_signal: assert property (p_signal)
		else $error("signal output differs from presence");

	property p_discrep;
		s_one_falls |=> pl_q == PL_DISCREP;
	endproperty
	a_discrep: assert property (p_discrep)
		else $error("discrepancy not flagged");

	property p_lock;
		s_returns |=> lock_out && plaus_err_out ##1 (lock_out || (!$past(s1) && !$past(s2)));
	endproperty
	a_lock: assert property (p_lock)
		else $error("plausibility lock not latched");

	property p_release;
		ce_in && warm_q[1] && !s1 && !s2 |=> pl_q == PL_NORMAL && !lock_out;
	endproperty
	a_release: assert property (p_release)
		else $error("both-low did not release");

	property p_lock_hold;
		ce_in && pl_q == PL_LOCKED && (s1 || s2) |=> pl_q == PL_LOCKED;
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("lock left without both inputs low");

	property p_ignore;
		!diag_mode_out |-> !rx_busy_q && !tx_busy_q;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("diagnostic link active without module");

	property p_tx_line;
		ce_in && diag_mode_out && tx_busy_q |=> signal_diag_out_out == $past(tx_sh_q[0]);
	endproperty
	a_tx_line: assert property (p_tx_line)
		else $error("signal output not carrying diagnostic data");

	property p_refresh;
		ce_in && dg_q == DG_IDLE && addr_hit_w && rx_sh_q[3:0] == `SGOL_OP_REFRESH
			|=> name_refresh_out ##1 !name_refresh_out;
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("refresh action not performed");

	property p_learn_once;
		learned_q |=> learned_q && code_q == $past(code_q);
	endproperty
	a_learn_once: assert property (p_learn_once)
		else $error("a second actuator was learned");

endmodule

`default_nettype wire

// ==== verif/sgol_diag_master.sv ====
// diagnostic fieldbus module model: frames on the receive line, collects answers
`timescale 1ns/10ps
`default_nettype none

module sgol_diag_master #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic mclk_in,
	input wire logic line_in,
	output logic line_out
);
	logic attached = 1'b0;
	logic [7:0] rx_q[$];
	logic [7:0] sh;

	initial line_out = 1'b0;

	// an attached module pulls the line up between frames, so the switch finds it
	task automatic set_attached(input logic a);
		@(posedge mclk_in);
		attached <= a;
		line_out <= a;
	endtask

	// start 0, data lsb first, stop 1; address field picks one of 16 subscribers
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge mclk_in);
			line_out <= fr[i];
			repeat (BIT_CYCLES - 1) @(posedge mclk_in);
		end
	endtask

	// mid-bit sampling; frames with a bad stop bit are dropped
	always begin
		@(posedge mclk_in);
		if (attached === 1'b1 && line_in === 1'b0) begin
			repeat (BIT_CYCLES / 2) @(posedge mclk_in);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge mclk_in);
				sh[i] = line_in;
			end
			repeat (BIT_CYCLES) @(posedge mclk_in);
			if (line_in === 1'b1) rx_q.push_back(sh);
		end
	end
endmodule

`default_nettype wire

// ==== verif/sgol_top_tb.sv ====
// self-checking testbench of the safety gate output logic
`timescale 1ns/10ps
`default_nettype none

module sgol_top_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic det = 1'b0;
	logic [7:0] code = 8'h00;
	logic s1 = 1'b1;
	logic s2 = 1'b1;
	logic ce = 1'b1;
	logic [7:0] serial = 8'ha7;
	logic [3:0] teach = 4'h9;
	logic dline;
	logic o1, o2, sig, flash, perr, lock, dmode, pres, nref;
	logic [7:0] param;
	int n_fail = 0;
	int total_checks = 0;
	int n_ref = 0;

	always #2 mclk = ~mclk;
	always @(posedge mclk) if (nref === 1'b1) n_ref++;

	sgol_top #(.DEV_ADDR(15), .BIT_CYCLES(8), .DET_CYCLES(16), .FLASH_CYCLES(4)) sgol_top_i (
		.mclk_in(mclk), .rst_in(rst), .ce_in(ce), .act_detect_in(det),
		.act_code_in(code), .safety_in_ch1_in(s1), .safety_in_ch2_in(s2),
		.diag_in_in(dline), .serial_num_in(serial), .teach_left_in(teach),
		.safety_out_ch1_out(o1), .safety_out_ch2_out(o2), .signal_diag_out_out(sig),
		.input_led_flash_out(flash), .plaus_err_out(perr), .lock_out(lock),
		.diag_mode_out(dmode), .act_present_out(pres), .name_refresh_out(nref),
		.param_out(param)
	);

	sgol_diag_master #(.BIT_CYCLES(8)) sgol_diag_master_i (
		.mclk_in(mclk), .line_in(sig), .line_out(dline)
	);

	task automatic wrap_up();
		if (n_fail == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic set_in(input logic a, input logic b);
		@(posedge mclk);
		s1 <= a;
		s2 <= b;
		cyc(6);
	endtask

	task automatic do_reset();
		@(posedge mclk);
		rst <= 1'b1;
		cyc(16);
		rst <= 1'b0;
		cyc(1);
	endtask

	task automatic timeout();
		n_fail++;
		$display("Error at %0t: wait ran out", $time);
		wrap_up();
	endtask

	task automatic t_follow();
		logic [1:0] tab[3] = '{2'b10, 2'b01, 2'b11};
		@(posedge mclk);
		det <= 1'b1;
		code <= 8'h5a;
		set_in(1'b1, 1'b1);
		chk({o1, o2}, 2'b00);
		chk(sig, 1'b1);
		set_in(1'b0, 1'b0);
		foreach (tab[i]) begin
			set_in(tab[i][1], tab[i][0]);
			chk({o1, o2}, tab[i]);
		end
	endtask

	task automatic t_absent();
		@(posedge mclk);
		det <= 1'b0;
		cyc(6);
		chk({o1, o2, sig, pres}, 4'h0);
		@(posedge mclk);
		det <= 1'b1;
		code <= 8'h33;
		cyc(6);
		chk({o1, o2, pres}, 3'b000);
		@(posedge mclk);
		code <= 8'h5a;
		cyc(6);
		chk({o1, o2, sig}, 3'b111);
	endtask

	// clock enable low freezes every output although inputs and presence change
	task automatic t_freeze();
		@(posedge mclk);
		ce <= 1'b0;
		s1 <= 1'b0;
		s2 <= 1'b0;
		det <= 1'b0;
		cyc(6);
		chk({o1, o2, pres}, 3'b111);
		@(posedge mclk);
		ce <= 1'b1;
		det <= 1'b1;
		cyc(6);
		chk({o1, o2, pres}, 3'b001);
		set_in(1'b1, 1'b1);
	endtask

	task automatic t_plaus();
		logic hi, lo;
		set_in(1'b0, 1'b1);
		chk({o1, o2, lock}, 3'b010);
		hi = 1'b0;
		lo = 1'b0;
		repeat (12) begin
			@(posedge mclk);
			if (flash === 1'b1) hi = 1'b1;
			if (flash === 1'b0) lo = 1'b1;
		end
		chk(hi & lo, 1'b1);
		set_in(1'b1, 1'b1);
		chk({o1, o2, lock, perr}, 4'b0011);
		chk({o1, o2}, 2'b00);
		set_in(1'b0, 1'b0);
		chk({lock, perr}, 2'b00);
		set_in(1'b1, 1'b1);
		chk({o1, o2, flash}, 3'b110);
	endtask

	task automatic wait_diag();
		for (int i = 0; i < 200; i++) begin
			@(posedge mclk);
			if (dmode === 1'b1) return;
		end
		timeout();
	endtask

	task automatic cmd(input logic [7:0] b, input logic [7:0] exp);
		sgol_diag_master_i.send_byte(b);
		for (int i = 0; i < 400; i++) begin
			@(posedge mclk);
			if (sgol_diag_master_i.rx_q.size() > 0) begin
				chk(sgol_diag_master_i.rx_q.pop_front(), exp);
				return;
			end
		end
		timeout();
	endtask

	task automatic t_diag();
		int r0;
		chk(dmode, 1'b0);
		sgol_diag_master_i.set_attached(1'b1);
		wait_diag();
		cyc(40);
		sgol_diag_master_i.rx_q.delete();
		chk(sig, 1'b1);
		cmd(8'hf1, 8'h8f);
		cmd(8'hf2, 8'ha7);
		cmd(8'hf3, 8'h09);
		cmd(8'hf4, 8'h5a);
		sgol_diag_master_i.send_byte(8'hf5);
		cmd(8'h3c, 8'h06);
		chk(param, 8'h3c);
		r0 = n_ref;
		cmd(8'hf6, 8'h06);
		chk(8'(n_ref - r0), 8'h01);
		sgol_diag_master_i.send_byte(8'h01);
		cyc(300);
		chk(8'(sgol_diag_master_i.rx_q.size()), 8'h00);
	endtask

	task automatic t_repower();
		do_reset();
		chk({dmode, o1, o2, lock}, 4'h0);
		wait_diag();
		// the master may still collect a frame begun while reset held the line low
		cyc(100);
		sgol_diag_master_i.rx_q.delete();
		cmd(8'hf1, 8'h8f);
		@(posedge mclk);
		serial <= 8'h3e;
		teach <= 4'h2;
		cmd(8'hf2, 8'h3e);
		cmd(8'hf3, 8'h02);
		chk({o1, o2}, 2'b00);
	endtask

	initial begin
		cyc(16);
		rst <= 1'b0;
		cyc(1);
		t_follow();
		t_absent();
		t_freeze();
		t_plaus();
		t_diag();
		t_repower();
		wrap_up();
	end
endmodule

`default_nettype wire
